/* cfb_cond.sv */
// Condition evaluator: picks the tested flag and its polarity
// Assumes the status byte is stable while a branch is decoded
`timescale 1ns/100ps
module cfb_cond
	import cfb_pkg::*;
(
	input  wire logic [7:0] sreg,
	input  wire cfb_op_e    op,
	output logic            take
);

	logic flag;

	always_comb begin
		unique case (op)
			CFB_HALF_SET, CFB_HALF_CLR: flag = sreg[FLAG_H];
			CFB_TBIT_SET, CFB_TBIT_CLR: flag = sreg[FLAG_T];
			CFB_OVF_SET,  CFB_OVF_CLR:  flag = sreg[FLAG_V];
			CFB_INT_EN,   CFB_INT_DIS:  flag = sreg[FLAG_I];
		endcase
		// Even codes test for set, odd codes for clear
		take = op[0] ? ~flag : flag;
	end

endmodule // cfb_cond

/* cfb_pkg.sv */
// Constants and types for the conditional flag branch unit
// Assumes a 16-bit word-addressed program counter and a 7-bit offset
package cfb_pkg;

	localparam int PC_W  = 16;
	localparam int OFF_W = 7;

	// Status register bit positions
	localparam int FLAG_T = 6;
	localparam int FLAG_H = 5;
	localparam int FLAG_V = 3;
	localparam int FLAG_I = 7;

	localparam logic [PC_W-1:0] PC_RESET = 16'h0000;
	localparam logic [7:0]      SREG_RESET = 8'h00;

	// Cycles spent per branch outcome
	localparam int CYC_NOT_TAKEN = 1;
	localparam int CYC_TAKEN     = 2;

	// Branch selector codes
	typedef enum logic [2:0] {
		CFB_HALF_SET,
		CFB_HALF_CLR,
		CFB_TBIT_SET,
		CFB_TBIT_CLR,
		CFB_OVF_SET,
		CFB_OVF_CLR,
		CFB_INT_EN,
		CFB_INT_DIS
	} cfb_op_e;

endpackage

/* cfb_unit.sv */
// Branch resolution for eight flag-tested relative branches
// Assumes the core presents one branch with a one-cycle issue strobe and
// waits while busy is high; flags come from the status register
`timescale 1ns/100ps

module cfb_unit
	import cfb_pkg::*;
(
	input  wire logic             mclk,
	input  wire logic             rstn,
	input  wire logic             issue,
	input  wire cfb_op_e          op,
	input  wire logic [OFF_W-1:0] offset,
	input  wire logic [PC_W-1:0]  pc_in,
	input  wire logic [7:0]       sreg_in,
	output logic [PC_W-1:0]       pc,
	output logic [7:0]            sreg_out,
	output logic                  busy,
	output logic                  done,
	output logic                  taken
);

	typedef enum logic [1:0] {CFB_IDLE, CFB_JUMP} cfb_state_e;

	cfb_state_e      state;
	logic            take;
	logic [PC_W-1:0] next_pc;
	logic [PC_W-1:0] target;

	// ************************************************
	// Condition and target
	// ************************************************
	cfb_cond u_cond (
		.sreg (sreg_in),
		.op   (op),
		.take (take)
	);

	// Sign extension lets short offsets go backward too
	assign target = PC_W'(pc_in + {{(PC_W-OFF_W){offset[OFF_W-1]}}, offset}
		+ PC_W'(1));
	assign next_pc = take ? target : PC_W'(pc_in + PC_W'(1));

	a_half_sel: assert property (
		@(posedge mclk) disable iff (!rstn)
		(issue && op == CFB_HALF_SET)
		|-> take == sreg_in[FLAG_H])
		else $error("half carry test wrong");

	a_half_clr: assert property (
		@(posedge mclk) disable iff (!rstn)
		(issue && op == CFB_HALF_CLR)
		|-> take == !sreg_in[FLAG_H])
		else $error("half carry clear test wrong");

	a_tbit_set: assert property (
		@(posedge mclk) disable iff (!rstn)
		(issue && op == CFB_TBIT_SET)
		|-> take == sreg_in[FLAG_T])
		else $error("transfer bit set test wrong");

	a_tbit_sel: assert property (
		@(posedge mclk) disable iff (!rstn)
		(issue && op == CFB_TBIT_CLR)
		|-> take == !sreg_in[FLAG_T])
		else $error("transfer bit test wrong");

	a_ovf_sel: assert property (
		@(posedge mclk) disable iff (!rstn)
		(issue && op == CFB_OVF_SET)
		|-> take == sreg_in[FLAG_V])
		else $error("overflow test wrong");

	a_ovf_clr: assert property (
		@(posedge mclk) disable iff (!rstn)
		(issue && op == CFB_OVF_CLR)
		|-> take == !sreg_in[FLAG_V])
		else $error("overflow clear test wrong");

	a_int_sel: assert property (
		@(posedge mclk) disable iff (!rstn)
		(issue && op == CFB_INT_EN)
		|-> take == sreg_in[FLAG_I])
		else $error("interrupt enable test wrong");

	a_int_dis: assert property (
		@(posedge mclk) disable iff (!rstn)
		(issue && op == CFB_INT_DIS)
		|-> take == !sreg_in[FLAG_I])
		else $error("interrupt disable test wrong");

	// ************************************************
	// Sequencing
	// ************************************************
	// Taken branch holds busy for a second cycle like a pipeline refill
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			state <= CFB_IDLE;
		end else begin
			unique case (state)
				CFB_IDLE: if (issue && take) state <= CFB_JUMP;
				CFB_JUMP: state <= CFB_IDLE;
				default:  state <= CFB_IDLE;
			endcase
		end
	end

	assign busy = (state == CFB_JUMP);

	a_two_cycles: assert property (
		@(posedge mclk) disable iff (!rstn)
		(state == CFB_IDLE && issue && take)
		|=> (busy && !done) ##1 (done && !busy))
		else $error("taken branch not two cycles");

	a_one_cycle: assert property (
		@(posedge mclk) disable iff (!rstn)
		(state == CFB_IDLE && issue && !take)
		|=> !busy && !taken)
		else $error("untaken branch took two cycles");

	a_busy_single: assert property (
		@(posedge mclk) disable iff (!rstn)
		busy
		|=> !busy)
		else $error("busy stood too long");

	a_done_cause: assert property (
		@(posedge mclk) disable iff (!rstn)
		done
		|-> $past(busy) || $past(state == CFB_IDLE && issue && !take))
		else $error("done without a finished branch");

	a_taken_busy: assert property (
		@(posedge mclk) disable iff (!rstn)
		busy
		|-> taken)
		else $error("busy without a taken branch");

	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			pc    <= PC_RESET;
			done  <= 1'b0;
			taken <= 1'b0;
		end else begin
			done <= 1'b0;
			if (state == CFB_IDLE && issue) begin
				pc    <= next_pc;
				taken <= take;
				done  <= ~take;
			end else if (state == CFB_JUMP) begin
				done <= 1'b1;
			end
		end
	end

	a_taken_target: assert property (
		@(posedge mclk) disable iff (!rstn)
		(state == CFB_IDLE && issue && take)
		|=> pc == PC_W'($past(pc_in) + 16'h0001
			+ {{(PC_W-OFF_W){$past(offset[OFF_W-1])}}, $past(offset)}))
		else $error("taken branch target wrong");

	a_fall_through: assert property (
		@(posedge mclk) disable iff (!rstn)
		(state == CFB_IDLE && issue && !take)
		|=> (pc == $past(pc_in) + 16'h0001) && done)
		else $error("untaken branch did not fall through");

	a_back_jump: assert property (
		@(posedge mclk) disable iff (!rstn)
		(state == CFB_IDLE && issue && take && offset[OFF_W-1])
		|=> PC_W'($past(pc_in) - pc) == {{(PC_W-OFF_W){1'b0}}, ~$past(offset)})
		else $error("negative offset not backward");

	a_fwd_jump: assert property (
		@(posedge mclk) disable iff (!rstn)
		(state == CFB_IDLE && issue && take && !offset[OFF_W-1])
		|=> PC_W'(pc - $past(pc_in))
			== {{(PC_W-OFF_W){1'b0}}, $past(offset)} + 16'h0001)
		else $error("positive offset not forward");

	a_busy_refuse: assert property (
		@(posedge mclk) disable iff (!rstn)
		(busy && issue)
		|=> pc == $past(pc) && taken == $past(taken))
		else $error("issue while busy was taken");

	a_pc_holds: assert property (
		@(posedge mclk) disable iff (!rstn)
		!(state == CFB_IDLE && issue)
		|=> $stable(pc))
		else $error("pc moved without a branch");

	// Flags pass through; no branch alters them
	always_ff @(posedge mclk or negedge rstn) begin
		if (!rstn) begin
			sreg_out <= SREG_RESET;
		end else begin
			sreg_out <= sreg_in;
		end
	end

	a_flags_kept: assert property (
		@(posedge mclk) disable iff (!rstn)
		issue
		|=> sreg_out == $past(sreg_in))
		else $error("branch changed flags");

	a_flags_busy: assert property (
		@(posedge mclk) disable iff (!rstn)
		busy
		|=> sreg_out == $past(sreg_in))
		else $error("flags changed during jump");

endmodule // cfb_unit

/* tb.sv */
// Self-checking bench for the conditional flag branch unit
// Assumes cfb_pkg, cfb_cond and cfb_unit are compiled first; no other parts needed
`timescale 1ns/100ps
module tb;
	import cfb_pkg::*;

	// ****************************************
	// Stimulus and observed signals
	// ****************************************
	logic             mclk    = 1'b0;
	logic             rstn    = 1'b0;
	logic             issue   = 1'b0;
	cfb_op_e          op      = CFB_HALF_SET;
	logic [OFF_W-1:0] offset  = '0;
	logic [PC_W-1:0]  pc_in   = '0;
	logic [7:0]       sreg_in = 8'h00;
	logic [PC_W-1:0]  pc;
	logic [7:0]       sreg_out;
	logic             busy;
	logic             done;
	logic             taken;
	int               error_cnt    = 0;
	int               total_checks = 0;
	int               cycles       = 0;

	always #4 mclk = ~mclk;

	cfb_unit i_cfb_unit (.mclk(mclk), .rstn(rstn), .issue(issue), .op(op),
		.offset(offset), .pc_in(pc_in), .sreg_in(sreg_in), .pc(pc),
		.sreg_out(sreg_out), .busy(busy), .done(done), .taken(taken));

	// ****************************************
	// Expectations and checks
	// ****************************************
	function automatic logic exp_take(input cfb_op_e o, input logic [7:0] s);
		logic f;
		case (o[2:1])
			2'h0: f = s[FLAG_H];
			2'h1: f = s[FLAG_T];
			2'h2: f = s[FLAG_V];
			default: f = s[FLAG_I];
		endcase
		return o[0] ? !f : f;
	endfunction

	// Sign extension lets the jump reach backward
	function automatic logic [PC_W-1:0] exp_pc(input logic [PC_W-1:0] p,
		input logic [OFF_W-1:0] k, input logic t);
		return t ? p + {{(PC_W-OFF_W){k[OFF_W-1]}}, k} + 16'h0001 : p + 16'h0001;
	endfunction

	task automatic chk(input logic [PC_W-1:0] got, input logic [PC_W-1:0] exp);
		total_checks++;
		if (got !== exp) begin
			error_cnt++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic conclude();
		if (error_cnt == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	// Called at a falling edge; returns at a falling edge after done falls
	task automatic branch(input cfb_op_e o, input logic [OFF_W-1:0] k,
		input logic [PC_W-1:0] p, input logic [7:0] s);
		logic t;
		int   n;
		t = exp_take(o, s);
		n = 1;
		op = o;
		offset = k;
		pc_in = p;
		sreg_in = s;
		issue = 1'b1;
		@(negedge mclk);
		issue = 1'b0;
		chk(pc, exp_pc(p, k, t));
		chk(16'(taken), 16'(t));
		chk(16'(sreg_out), 16'(s));
		chk(16'({done, busy}), 16'({!t, t}));
		while (done !== 1'b1 && n < 4) begin
			@(negedge mclk);
			n++;
		end
		chk(16'(n), 16'(t ? CYC_TAKEN : CYC_NOT_TAKEN));
		chk(16'({done, busy}), 16'h0002);
		// One idle edge so issue is never rewritten in one time step
		@(negedge mclk);
		chk(16'({done, busy}), 16'h0000);
	endtask

	// A second issue while busy is dropped without a trace
	task automatic refused(input logic [PC_W-1:0] p,
		input logic [OFF_W-1:0] k);
		logic [PC_W-1:0] e;
		e = exp_pc(p, k, 1'b1);
		op = CFB_INT_EN;
		offset = k;
		pc_in = p;
		sreg_in = 8'h80;
		issue = 1'b1;
		@(negedge mclk);
		pc_in = ~p;
		op = CFB_INT_DIS;
		sreg_in = 8'h00;
		chk(16'(busy), 16'h0001);
		@(negedge mclk);
		issue = 1'b0;
		chk(pc, e);
		chk(16'({done, busy, taken}), 16'h0005);
		@(negedge mclk);
		chk(pc, e);
		chk(16'({done, busy}), 16'h0000);
	endtask

	// ****************************************
	// Main sequence and hang guard
	// ****************************************
	always @(posedge mclk) begin
		cycles++;
		if (cycles == 3000) begin
			error_cnt++;
			conclude();
		end
	end

	initial begin
		void'($urandom(69));
		repeat (8) @(negedge mclk);
		chk(pc, PC_RESET);
		chk(16'({busy, done, taken}), 16'h0000);
		chk(16'(sreg_out), 16'(SREG_RESET));
		rstn = 1'b1;
		@(negedge mclk);
		// Every code with all flags set, then all clear, most negative k
		for (int i = 0; i < 16; i++)
			branch(cfb_op_e'(i[2:0]), 7'h40, 16'h0010, i < 8 ? 8'hff : 8'h00);
		branch(CFB_INT_EN, 7'h3f, 16'hffff, 8'h80);
		branch(CFB_OVF_CLR, 7'h7f, 16'h0000, 8'h00);
		refused(16'h0100, 7'h05);
		refused(16'h0008, 7'h40);
		// Reset in mid-branch drops the pending jump
		op = CFB_TBIT_SET;
		sreg_in = 8'h40;
		pc_in = 16'h1234;
		issue = 1'b1;
		@(negedge mclk);
		issue = 1'b0;
		rstn = 1'b0;
		@(negedge mclk);
		chk(pc, PC_RESET);
		chk(16'({busy, done, taken}), 16'h0000);
		chk(16'(sreg_out), 16'(SREG_RESET));
		rstn = 1'b1;
		@(negedge mclk);
		branch(CFB_TBIT_SET, 7'h02, 16'h1234, 8'h40);
		for (int i = 0; i < 200; i++)
			branch(cfb_op_e'($urandom_range(7)), 7'($urandom), 16'($urandom),
				8'($urandom));
		conclude();
	end
endmodule // tb
